// *** shared/lpm_consts.vh ***
/*
  Constants for the low power mode sequencer: register offsets, field
  positions, reset values, calendar load values and timing counts.
  Assumes it is included by bare name into plain Verilog-2005 design files.
*/
`ifndef LPM_CONSTS_VH
`define LPM_CONSTS_VH

// Register word indices on the AXI4-Lite slave; the byte address is four times.
`define REG_CTRL       6'h00
`define REG_STATUS     6'h01
`define REG_IRQ_STATUS 6'h02
`define REG_IRQ_MASK   6'h03
`define REG_PRIORITY   6'h04
`define REG_RTC_TIME   6'h05
`define REG_RTC_DATE   6'h06

// Control register fields.
`define CTRL_MODE_LSB   0
`define CTRL_SRC_LSB    2
`define CTRL_WAIT_BIT   8
`define CTRL_REARM_BIT  9
`define CTRL_RESET      32'h00000000

// Low power mode encodings.
`define MODE_SLEEP      2'h0
`define MODE_SOFT_STBY  2'h1
`define MODE_DEEP_STBY  2'h2

// Wake source encodings.
`define SRC_PIN         2'h0
`define SRC_MONITOR     2'h1
`define SRC_RTC         2'h2

// Interrupt status and mask bit positions.
`define IRQ_PIN         0
`define IRQ_RISE        1
`define IRQ_FALL        2
`define IRQ_TICK        3
`define IRQ_ENTERED     4
`define IRQ_EXITED      5
`define IRQ_MASK_RESET  6'h00

// Priority level of every wake source interrupt.
`define WAKE_PRIORITY   4'hf

// AXI response codes.
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

// Calendar load values: 2013-01-01, Tuesday, 00:00:00, 24-hour counting.
`define RTC_INIT_YEAR   12'h7dd
`define RTC_INIT_MONTH  4'h1
`define RTC_INIT_DAY    5'h01
`define RTC_INIT_WDAY   3'h2
`define RTC_INIT_HOUR   5'h00
`define RTC_INIT_MIN    6'h00
`define RTC_INIT_SEC    6'h00

// Timing: clock rate, one calendar second, tick period in seconds.
`define CLK_HZ          200000000
`define RTC_SECOND_S    1
`define TICK_PERIOD_S   2'h2
`define INIT_CYCLES     5'h10
`define DEEP_RST_CYCLES 5'h08

`endif

// *** hdl/rtc_calendar.v ***
/*
  Calendar counter with a periodic tick every two seconds.
  Assumes a one-cycle second enable from the parent's divider and a
  load pulse whenever the parent reruns its initial setup.
*/
`timescale 1ns/1ps
`include "lpm_consts.vh"

module rtc_calendar (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire        load,
   input  wire        sec_en,
   output reg  [5:0]  sec,
   output reg  [5:0]  min,
   output reg  [4:0]  hour,
   output reg  [4:0]  day,
   output reg  [3:0]  month,
   output reg  [11:0] year,
   output reg  [2:0]  weekday,
   output reg         tick
);

   reg [1:0] tick_phase;   // Seconds elapsed inside the current tick period.

   // Days in a month; the simple leap test holds for years 1901 to 2099.
   function [4:0] month_days;
      input [3:0]  m;
      input [11:0] y;
      begin
         case (m)
            4'h2: month_days = (y[1:0] == 2'h0) ? 5'h1d : 5'h1c;
            4'h4, 4'h6, 4'h9, 4'hb: month_days = 5'h1e;
            default: month_days = 5'h1f;
         endcase
      end
   endfunction

   // Calendar advance; the load sets the fixed start date and time.
   always @(posedge aclk) begin
      if (!aresetn || load) begin
         sec        <= `RTC_INIT_SEC; // RULE8
         min        <= `RTC_INIT_MIN;
         hour       <= `RTC_INIT_HOUR;
         day        <= `RTC_INIT_DAY;
         month      <= `RTC_INIT_MONTH;
         year       <= `RTC_INIT_YEAR;
         weekday    <= `RTC_INIT_WDAY;
         tick       <= 1'b0;
         tick_phase <= 2'h0;
      end else begin
         tick <= 1'b0;
         if (sec_en) begin
            // The tick fires once per period of whole seconds.
            if (tick_phase == `TICK_PERIOD_S - 2'h1) begin
               tick_phase <= 2'h0;
               tick       <= 1'b1; // RULE7
            end else begin
               tick_phase <= tick_phase + 2'h1;
            end
            if (sec != 6'h3b) begin
               sec <= sec + 6'h1;
            end else begin
               sec <= 6'h00;
               if (min != 6'h3b) begin
                  min <= min + 6'h1;
               end else begin
                  min <= 6'h00;
                  // Hours wrap at 23 because the counter runs in 24-hour form.
                  if (hour != 5'h17) begin
                     hour <= hour + 5'h1; // RULE8
                  end else begin
                     hour    <= 5'h00;
                     weekday <= (weekday == 3'h6) ? 3'h0 : weekday + 3'h1;
                     if (day != month_days(month, year)) begin
                        day <= day + 5'h1;
                     end else begin
                        day <= 5'h01;
                        if (month != 4'hc) begin
                           month <= month + 4'h1;
                        end else begin
                           month <= 4'h1;
                           year  <= year + 12'h1;
                        end
                     end
                  end
               end
            end
         end
      end
   end

endmodule

// *** hdl/low_power_mode_sequencer.v ***
/*
  Low power mode sequencer: AXI4-Lite registers, wake source edges, a
  calendar with periodic tick, indicator pins and one level interrupt.
  Assumes pin inputs synchronous to aclk, one write and one read at a time.
*/
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "lpm_consts.vh"

// Operation
// RULE1: Three low power modes, one chosen per entry.
// RULE2: One wake source selected for entry and exit.
// RULE3: Wake pin requests on falling edges, unfiltered.
// RULE4: All wake source interrupts at priority 15.
// RULE5: Rising monitor requests on crossing upper threshold.
// RULE6: Falling monitor requests on crossing lower threshold.
// RULE7: Periodic tick request every two seconds.
// RULE8: Calendar starts 2013-01-01 Tuesday, 24-hour.
// RULE9: Ready lit, then entering lit on entry trigger.
// RULE10: Sleep or standby exit lights exited indicator.
// RULE11: Deep standby exit resets, reinitialises, lights exited.
// RULE12: Pin request enters when waiting, exits when low.
// RULE13: Tick enters when waiting, exits when low.
// RULE14: Falling monitor enters, rising monitor exits.
// RULE15: Switch drives pin; three lamp outputs.
// RULE16: Wait command enters the mode selected then.
module low_power_mode_sequencer #(
   parameter CYCLES_PER_SECOND = `CLK_HZ * `RTC_SECOND_S
) (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        wake_port_pin,
   input  wire        supply_above_upper,
   input  wire        supply_below_lower,
   output reg         ready_indicator_pin,
   output reg         entering_indicator_pin,
   output reg         exited_indicator_pin,
   output reg         sleep_active,
   output reg         soft_standby_active,
   output reg         deep_standby_active,
   output wire        irq
);

   // Sequencer states, one-hot.
   localparam [5:0] S_INIT   = 6'h01;  // Initial setup in progress.
   localparam [5:0] S_READY  = 6'h02;  // Waiting for the entry trigger.
   localparam [5:0] S_ARMED  = 6'h04;  // Entry seen, waiting for the wait command.
   localparam [5:0] S_LOW    = 6'h08;  // Inside the low power mode.
   localparam [5:0] S_RESET  = 6'h10;  // Internal reset after deep standby exit.
   localparam [5:0] S_EXITED = 6'h20;  // Mode left, exited indicator lit.

   reg  [5:0]  state;           // Current sequencer state.
   reg  [5:0]  next_state;      // State for the next edge.
   reg  [4:0]  phase_cnt;       // Cycle count inside init and reset states.
   reg         deep_exit;       // Survives the internal reset of deep exit.
   reg  [1:0]  mode_sel;        // Software choice of low power mode.
   reg  [1:0]  src_sel;         // Software choice of wake source.
   reg  [1:0]  active_mode;     // Mode latched at the wait command.
   reg  [5:0]  irq_status;      // Sticky event bits.
   reg  [5:0]  irq_mask;        // Enables for the interrupt output.
   reg         pin_q;           // Previous pin level for edge detection.
   reg         above_q;         // Previous upper comparator level.
   reg         below_q;         // Previous lower comparator level.
   reg  [31:0] sec_cnt;         // Divider for the one second enable.
   reg         sec_en;          // One-cycle second enable.
   reg         aw_held;         // Write address captured.
   reg         w_held;          // Write data captured.
   reg  [5:0]  aw_idx;          // Captured write word index.
   reg         aw_ok;           // Captured write address is word aligned and low.
   reg  [31:0] w_data;          // Captured write data.
   reg  [3:0]  w_strb;          // Captured write strobes.
   wire [5:0]  rtc_sec;
   wire [5:0]  rtc_min;
   wire [4:0]  rtc_hour;
   wire [4:0]  rtc_day;
   wire [3:0]  rtc_month;
   wire [11:0] rtc_year;
   wire [2:0]  rtc_wday;
   wire        periodic_tick_interrupt;  // Tick from the calendar.
   wire        external_wake_pin_interrupt;
   wire        rising_voltage_monitor;
   wire        falling_voltage_monitor;
   wire        entry_trig;      // Entry trigger of the selected source.
   wire        exit_trig;       // Exit trigger of the selected source.
   wire        wr_fire;         // A captured write is carried out.
   wire        rd_fire;         // A read address is taken.
   wire        wait_cmd;        // Software wait command.
   wire        rearm_cmd;       // Software request to run again.
   wire [5:0]  ev_set;          // Events setting sticky bits this cycle.
   wire        rd_clear;        // Read of the interrupt status register clears it.
   wire [5:0]  rd_idx;          // Read word index.
   wire        rd_ok;           // Read address maps to a register.
   wire        stay_low;        // Low power state held across this edge.

   // True when an address is word aligned and hits a mapped register.
   function addr_ok;
      input [7:0] a;
      begin
         addr_ok = (a[1:0] == 2'h0) && (a[7:2] <= `REG_RTC_DATE);
      end
   endfunction

   // Calendar and periodic tick.
   rtc_calendar u_rtc (
      .aclk    (aclk),
      .aresetn (aresetn),
      .load    (state == S_INIT && phase_cnt == 5'h00),
      .sec_en  (sec_en),
      .sec     (rtc_sec),
      .min     (rtc_min),
      .hour    (rtc_hour),
      .day     (rtc_day),
      .month   (rtc_month),
      .year    (rtc_year),
      .weekday (rtc_wday),
      .tick    (periodic_tick_interrupt)
   );

   // One second enable; the divider runs in every mode so no time is lost in sleep or soft standby.
   always @(posedge aclk) begin
      if (!aresetn) begin
         sec_cnt <= 32'h0;
         sec_en  <= 1'b0;
      end else if (sec_cnt == CYCLES_PER_SECOND - 1) begin
         sec_cnt <= 32'h0;
         sec_en  <= 1'b1;
      end else begin
         sec_cnt <= sec_cnt + 32'h1;
         sec_en  <= 1'b0;
      end
   end

   // Previous levels of the pin and comparators, for edge detection.
   // No filter stage sits here, so a one-cycle glitch is a real request.
   always @(posedge aclk) begin
      if (!aresetn) begin
         pin_q   <= 1'b1;
         above_q <= 1'b1;
         below_q <= 1'b0;
      end else begin
         pin_q   <= wake_port_pin;
         above_q <= supply_above_upper;
         below_q <= supply_below_lower;
      end
   end

   // Requests: falling pin edge (the switch pulls low) and both threshold crossings.
   assign external_wake_pin_interrupt = pin_q & ~wake_port_pin; // RULE3 RULE15
   assign rising_voltage_monitor = ~above_q & supply_above_upper; // RULE5
   assign falling_voltage_monitor = ~below_q & supply_below_lower; // RULE6

   // Entry and exit triggers of the one selected source.
   assign entry_trig = (src_sel == `SRC_PIN)     ? external_wake_pin_interrupt :
                       (src_sel == `SRC_MONITOR) ? falling_voltage_monitor : // RULE14
                       (src_sel == `SRC_RTC)     ? periodic_tick_interrupt : // RULE2 RULE13
                       1'b0;
   assign exit_trig  = (src_sel == `SRC_PIN)     ? external_wake_pin_interrupt : // RULE12
                       (src_sel == `SRC_MONITOR) ? rising_voltage_monitor : // RULE14
                       (src_sel == `SRC_RTC)     ? periodic_tick_interrupt : // RULE13
                       1'b0;

   // Write channel: address and data are captured in either order.
   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
   assign wr_fire       = aw_held & w_held & ~s_axi_bvalid;
   assign wait_cmd      = wr_fire & aw_ok & (aw_idx == `REG_CTRL) & w_strb[1] &
                          w_data[`CTRL_WAIT_BIT];
   assign rearm_cmd     = wr_fire & aw_ok & (aw_idx == `REG_CTRL) & w_strb[1] &
                          w_data[`CTRL_REARM_BIT];

   // Write capture, register update and response.
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_idx       <= 6'h00;
         aw_ok        <= 1'b0;
         w_data       <= 32'h0;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RESP_OKAY;
         mode_sel     <= `MODE_SLEEP;
         src_sel      <= `SRC_PIN;
         irq_mask     <= `IRQ_MASK_RESET;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_idx  <= s_axi_awaddr[7:2];
            aw_ok   <= addr_ok(s_axi_awaddr);
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            // Read-only registers accept and ignore writes.
            s_axi_bresp  <= aw_ok ? `RESP_OKAY : `RESP_SLVERR;
            if (aw_ok && aw_idx == `REG_CTRL && w_strb[0]) begin
               mode_sel <= w_data[`CTRL_MODE_LSB +: 2]; // RULE1
               src_sel  <= w_data[`CTRL_SRC_LSB +: 2]; // RULE2
            end
            if (aw_ok && aw_idx == `REG_IRQ_MASK && w_strb[0]) begin
               irq_mask <= w_data[5:0];
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read channel: one read outstanding, data from a register.
   assign s_axi_arready = ~s_axi_rvalid;
   assign rd_fire       = s_axi_arvalid & s_axi_arready;
   assign rd_idx        = s_axi_araddr[7:2];
   assign rd_ok         = addr_ok(s_axi_araddr);
   assign rd_clear      = rd_fire & rd_ok & (rd_idx == `REG_IRQ_STATUS);

   // Read data mux and response.
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= `RESP_OKAY;
      end else if (rd_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
         s_axi_rdata  <= 32'h0;
         if (rd_ok) begin
            case (rd_idx)
               `REG_CTRL:       s_axi_rdata <= {28'h0, src_sel, mode_sel};
               `REG_STATUS:     s_axi_rdata <= {14'h0, active_mode, 3'h0, deep_exit, 2'h0, state,
                                                1'b0, exited_indicator_pin, entering_indicator_pin,
                                                ready_indicator_pin};
               `REG_IRQ_STATUS: s_axi_rdata <= {26'h0, irq_status};
               `REG_IRQ_MASK:   s_axi_rdata <= {26'h0, irq_mask};
               // Every wake source sits at the same fixed priority level.
               `REG_PRIORITY:   s_axi_rdata <= {20'h0, {3{`WAKE_PRIORITY}}}; // RULE4
               `REG_RTC_TIME:   s_axi_rdata <= {11'h0, rtc_hour, 2'h0, rtc_min, 2'h0, rtc_sec};
               `REG_RTC_DATE:   s_axi_rdata <= {1'b0, rtc_wday, rtc_year, 4'h0,
                                                rtc_month, 3'h0, rtc_day};
               default:         s_axi_rdata <= 32'h0;
            endcase
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Event bits feeding the sticky status register.
   assign ev_set = {(state == S_LOW) & exit_trig,
                    (state == S_ARMED) & wait_cmd,
                    periodic_tick_interrupt,
                    falling_voltage_monitor,
                    rising_voltage_monitor,
                    external_wake_pin_interrupt};

   // Sticky status; an event in the clearing cycle still sets its bit.
   always @(posedge aclk) begin
      if (!aresetn) begin
         irq_status <= 6'h00;
      end else begin
         irq_status <= (rd_clear ? 6'h00 : irq_status) | ev_set;
      end
   end

   // Level interrupt while any unmasked status bit is set.
   assign irq = |(irq_status & irq_mask);

   // Next state of the sequencer.
   always @* begin
      next_state = state;
      case (state)
         S_INIT: begin
            if (phase_cnt == `INIT_CYCLES - 5'h1) begin
               next_state = deep_exit ? S_EXITED : S_READY; // RULE11
            end
         end
         S_READY: if (entry_trig) next_state = S_ARMED; // RULE9 RULE12
         S_ARMED: begin
            // Entry waits for the wait command, not for the trigger alone.
            if (wait_cmd) begin
               next_state = S_LOW; // RULE16
            end
         end
         S_LOW: begin
            if (exit_trig) begin
               next_state = (active_mode == `MODE_DEEP_STBY) ? S_RESET : S_EXITED; // RULE10
            end
         end
         S_RESET: begin
            if (phase_cnt == `DEEP_RST_CYCLES - 5'h1) begin
               next_state = S_INIT; // RULE11
            end
         end
         S_EXITED: if (rearm_cmd) next_state = S_READY;
         default: next_state = S_INIT;
      endcase
   end

   // State, phase counter, latched mode and retained deep exit flag.
   always @(posedge aclk) begin
      if (!aresetn) begin
         state       <= S_INIT;
         phase_cnt   <= 5'h00;
         deep_exit   <= 1'b0;
         active_mode <= `MODE_SLEEP;
      end else begin
         state     <= next_state;
         phase_cnt <= (next_state != state) ? 5'h00 : phase_cnt + 5'h1;
         if (state == S_ARMED && wait_cmd) begin
            // An undefined selection falls back to sleep.
            active_mode <= (mode_sel == `MODE_SOFT_STBY ||
                            mode_sel == `MODE_DEEP_STBY) ? mode_sel : `MODE_SLEEP; // RULE16 RULE1
         end
         if (state == S_RESET) begin
            deep_exit <= 1'b1; // RULE11
         end else if (rearm_cmd && state == S_EXITED) begin
            deep_exit <= 1'b0;
         end
      end
   end

   assign stay_low = (next_state == S_LOW) && (state == S_LOW);
   // Indicator pins and mode outputs, all from flip-flops.
   always @(posedge aclk) begin
      if (!aresetn) begin
         ready_indicator_pin    <= 1'b0;
         entering_indicator_pin <= 1'b0;
         exited_indicator_pin   <= 1'b0;
         sleep_active           <= 1'b0;
         soft_standby_active    <= 1'b0;
         deep_standby_active    <= 1'b0;
      end else begin
         ready_indicator_pin    <= (next_state == S_READY); // RULE9 RULE15
         entering_indicator_pin <= (next_state == S_ARMED) || (next_state == S_LOW); // RULE9
         exited_indicator_pin   <= (next_state == S_EXITED); // RULE10 RULE11
         sleep_active           <= stay_low && (active_mode == `MODE_SLEEP);
         soft_standby_active    <= stay_low && (active_mode == `MODE_SOFT_STBY);
         deep_standby_active    <= stay_low && (active_mode == `MODE_DEEP_STBY);
      end
   end

endmodule

// *** test/lpm_chk_asserts.sv ***
/* Checker for the lamp and mode outputs of the sequencer.
   Assumes it is bound into the sequencer top and sees only its ports. */
`timescale 1ns/1ps
module lpm_chk (
   input wire aclk,
   input wire aresetn,
   input wire ready_indicator_pin,
   input wire entering_indicator_pin,
   input wire exited_indicator_pin,
   input wire sleep_active,
   input wire soft_standby_active,
   input wire deep_standby_active
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // All lamps dark, as while the deep exit reset and setup run.
   sequence dark;
      !ready_indicator_pin && !entering_indicator_pin && !exited_indicator_pin;
   endsequence
   AST_LAMP_ONE: assert property ($onehot0({ready_indicator_pin,
      entering_indicator_pin, exited_indicator_pin})) else $error("two lamps lit");
   AST_MODE_ONE: assert property ($onehot0({sleep_active, soft_standby_active,
      deep_standby_active})) else $error("two modes active");
   AST_ENTER: assert property ($rose(entering_indicator_pin) |->
      $fell(ready_indicator_pin)) else $error("entering lit with ready on");
   AST_READY_FALL: assert property ($fell(ready_indicator_pin) |->
      entering_indicator_pin) else $error("ready off without entering");
   AST_MODE_RISE: assert property ($rose(sleep_active || soft_standby_active ||
      deep_standby_active) |-> entering_indicator_pin) else $error("mode without entry");
   AST_EXIT_LAMP: assert property ($rose(exited_indicator_pin) |->
      !entering_indicator_pin) else $error("exited lit with entering");
   AST_EXIT_SLEEP: assert property ($fell(sleep_active || soft_standby_active) |->
      ##[0:1] exited_indicator_pin) else $error("no exited lamp after exit");
   AST_DEEP_DARK: assert property ($fell(deep_standby_active) |-> dark [*8])
      else $error("lamp lit during deep exit reset");
endmodule
bind low_power_mode_sequencer lpm_chk u_chk (.aclk(aclk), .aresetn(aresetn),
   .ready_indicator_pin(ready_indicator_pin), .entering_indicator_pin(entering_indicator_pin),
   .exited_indicator_pin(exited_indicator_pin), .sleep_active(sleep_active),
   .soft_standby_active(soft_standby_active), .deep_standby_active(deep_standby_active));

// *** test/wake_env.sv ***
/* Model of the wake switch and the two supply monitor comparators.
   Assumes the bench calls its tasks from a process timed by aclk. */
`timescale 1ns/1ps
module wake_env (
   input  wire aclk,
   output reg  wake_port_pin,
   output reg  supply_above_upper,
   output reg  supply_below_lower
);
   // Switch released and supply healthy at power-up.
   initial {wake_port_pin, supply_above_upper, supply_below_lower} = 3'b110;
   // A press pulls the pin low for four cycles; no bounce is modelled.
   task press;
      begin
         @(posedge aclk) wake_port_pin <= 1'b0;
         repeat (4) @(posedge aclk);
         wake_port_pin <= 1'b1;
      end
   endtask
   // Supply sags through the upper and then the lower threshold.
   task sag;
      begin
         @(posedge aclk) supply_above_upper <= 1'b0;
         @(posedge aclk) supply_below_lower <= 1'b1;
      end
   endtask
   // Supply climbs back through both thresholds.
   task recover;
      begin
         @(posedge aclk) supply_below_lower <= 1'b0;
         @(posedge aclk) supply_above_upper <= 1'b1;
      end
   endtask
endmodule

// *** test/tb_low_power_mode_sequencer.sv ***
/* Bench for the sequencer: register bus, lamps, modes and interrupt.
   Assumes the wake model drives the pins and a second lasts 20 cycles. */
`timescale 1ns/1ps
module tb_low_power_mode_sequencer;
   reg         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ta, tw;
   reg  [7:0]  awaddr, araddr;
   reg  [31:0] wdata, rd;
   reg  [3:0]  wstrb;
   reg  [1:0]  resp;
   reg  [5:0]  mask;
   wire        awready, wready, bvalid, arready, rvalid, pin, up, low, rdy, ent, exi, irq;
   wire        slp, sst, dst;
   wire [1:0]  bresp, rresp;
   wire [31:0] rdata;
   integer     n_fail, checked, seed, i, n;
   low_power_mode_sequencer #(.CYCLES_PER_SECOND(20)) DUT (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .wake_port_pin(pin), .supply_above_upper(up), .supply_below_lower(low),
      .ready_indicator_pin(rdy), .entering_indicator_pin(ent), .exited_indicator_pin(exi),
      .sleep_active(slp), .soft_standby_active(sst), .deep_standby_active(dst), .irq(irq));
   wake_env env (.aclk(aclk), .wake_port_pin(pin), .supply_above_upper(up),
      .supply_below_lower(low));
   // Free-running 200 MHz clock.
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   // Compares and counts; case inequality keeps unknowns from matching.
   task chk(input string nm, input [31:0] seen, input [31:0] exp);
      begin
         checked = checked + 1;
         if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("MISMATCH %0s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   // One write: address and data offered together, each dropped once taken.
   task wr(input [7:0] a, input [31:0] d);
      begin
         @(posedge aclk);
         awaddr <= a;
         wdata <= d;
         {awvalid, wvalid, bready, ta, tw} <= 5'b11100;
         @(posedge aclk);
         while (!(ta && tw)) begin
            {ta, tw} = {ta | awready, tw | wready};
            {awvalid, wvalid} <= ~{ta, tw};
            if (!(ta && tw)) @(posedge aclk);
         end
         while (!bvalid) @(posedge aclk);
         resp = bresp;
         bready <= 1'b0;
      end
   endtask
   // One read; data and response taken at the edge where rvalid is seen.
   task rdr(input [7:0] a);
      begin
         @(posedge aclk);
         araddr <= a;
         {arvalid, rready} <= 2'b11;
         do @(posedge aclk); while (!arready);
         arvalid <= 1'b0;
         while (!rvalid) @(posedge aclk);
         {rd, resp} = {rdata, rresp};
         rready <= 1'b0;
      end
   endtask
   // Bounded wait until any selected lamp or mode output is high.
   task await(input [5:0] m);
      begin
         for (n = 0; n < 400 && !({rdy, ent, exi, slp, sst, dst} & m); n = n + 1)
            @(posedge aclk);
         #1;
      end
   endtask
   task wrap_up;
      begin
         $display("checked %0d n_fail %0d", checked, n_fail);
         if (n_fail == 0 && checked > 0) $display("bench passed");
         else $display("bench failed");
         $finish;
      end
   endtask
   // Watchdog; the sequence needs a few hundred cycles.
   initial begin
      #100000;
      n_fail = n_fail + 1;
      wrap_up;
   end
   // Main sequence: one pass per mode, each with its own wake source.
   initial begin
      {seed, n_fail, checked, awaddr, araddr, wdata} = {32'd43300, 64'd0, 48'd0};
      {awvalid, wvalid, bready, arvalid, rready, aresetn, wstrb} = 10'h00f;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      await(6'h20);
      chk("lamps", {rdy, ent, exi}, 3'b100);
      rdr(8'h10);
      chk("prio", rd, 32'h00000fff);
      rdr(8'h18);
      chk("date", rd, 32'h27dd0101);
      rdr(8'h3c);
      chk("resp", resp, 2'h2);
      mask = $random(seed);
      wr(8'h0c, mask);
      rdr(8'h0c);
      chk("mask", rd, mask);
      wr(8'h0c, 32'h30);
      wr(8'h00, 32'h100);
      chk("ignore", rdy, 1);
      for (i = 0; i < 3; i = i + 1) begin
         wr(8'h00, i * 5);
         if (i == 0) env.press;
         if (i == 1) env.sag;
         await(6'h10);
         chk("enter", {rdy, ent, exi}, 3'b010);
         wr(8'h00, i * 5 + 32'h100);
         chk("bresp", resp, 2'h0);
         await(6'h07);
         chk("mode", {slp, sst, dst}, 3'b100 >> i);
         if (i == 0) env.press;
         if (i == 1) env.recover;
         await(6'h08);
         chk("exit", {rdy, ent, exi}, 3'b001);
         chk("irq", irq, 1);
         rdr(8'h08);
         chk("events", rd[5:4], 2'b11);
         #1 chk("irqclr", irq, 0);
         wr(8'h00, i * 5 + 32'h200);
         await(6'h20);
         chk("rearm", rdy, 1);
      end
      wrap_up;
   end
endmodule
